// file: tpd_consts.svh
// tone pair detector: sampling, window, timing and reference constants
// assumes a 25 MHz system clock and a 1-bit zero-cross line input
`ifndef TPD_CONSTS_SVH
`define TPD_CONSTS_SVH

`define TPD_CLK_HZ 25000000
`define TPD_SAMPLE_HZ 8000
`define TPD_SAMPLE_DIV (`TPD_CLK_HZ / `TPD_SAMPLE_HZ)
`define TPD_DIV_W 12

`define TPD_WINDOW_MS 16
`define TPD_WINDOW_SAMPLES (`TPD_WINDOW_MS * `TPD_SAMPLE_HZ / 1000)
`define TPD_WIN_W 7

// least on-time, rounded up to whole samples
`define TPD_MIN_ON_MS 23
`define TPD_MIN_ON_SAMPLES ((`TPD_MIN_ON_MS * `TPD_SAMPLE_HZ + 999) / 1000)
`define TPD_ON_W 9

// no edge for this long ends the burst
`define TPD_IDLE_US 2000
`define TPD_IDLE_SAMPLES (`TPD_IDLE_US * `TPD_SAMPLE_HZ / 1000000)
`define TPD_IDLE_W 5

`define TPD_NUM_REF 18
`define TPD_PHASE_W 16
`define TPD_ACC_W 9
`define TPD_NRG_W 9
`define TPD_THR_W 9

// phase steps per sample, f * 65536 / 8000, entry 0 in the low bits:
// 662 697 732 770 809 852 894 941 988 1149 1209 1269 1336 1403 1477 1551 1633 1715 Hz
`define TPD_INC_TABLE {16'h36E1, 16'h3442, 16'h31A2, 16'h2F44, 16'h2CE5, 16'h2AC1, \
	16'h289C, 16'h26B0, 16'h24C5, 16'h1F9E, 16'h1E1D, 16'h1C9C, 16'h1B44, 16'h19E3, \
	16'h18A4, 16'h176D, 16'h164E, 16'h152F}

// nominal tones sit at every second slot: low group 1,3,5,7, high group 10,12,14,16
`define TPD_LOW_BASE 1
`define TPD_HIGH_BASE 10

`endif

// file: tpd_correlator.sv
// tone pair detector: one 1-bit correlator for a single analysis frequency
// assumes sample_en pulses once per 8 kHz sample, clear before each window
`timescale 1ns/10ps
`include "tpd_consts.svh"

module tpd_correlator (
	input wire logic clock,
	input wire logic rst,
	input wire logic clear,
	input wire logic sample_en,
	input wire logic line_bit,
	input wire logic [`TPD_PHASE_W-1:0] phase_inc,
	output logic [`TPD_NRG_W-1:0] energy
);
	tpd_pkg::tpd_corr_t s;
	tpd_pkg::tpd_corr_t next_s;
	logic ref_i;
	logic ref_q;
	logic [`TPD_NRG_W-1:0] mag_i;
	logic [`TPD_NRG_W-1:0] mag_q;

	// reference square waves in quadrature, made from a phase accumulator
	// instead of a stored bit table
	assign ref_i = s.phase[`TPD_PHASE_W-1];
	assign ref_q = s.phase[`TPD_PHASE_W-1] ^ s.phase[`TPD_PHASE_W-2];

	always_comb begin
		next_s = s;
		if (clear) begin
			next_s = '0;
		end else if (sample_en) begin
			next_s.phase = s.phase + phase_inc;
			next_s.acc_i = (line_bit == ref_i) ? s.acc_i + 9'sh001 : s.acc_i - 9'sh001;
			next_s.acc_q = (line_bit == ref_q) ? s.acc_q + 9'sh001 : s.acc_q - 9'sh001;
		end
	end

	// energy is the sum of match-count magnitudes, so phase of the tone does not matter
	assign mag_i = s.acc_i[`TPD_ACC_W-1] ? 9'(-s.acc_i) : 9'(s.acc_i);
	assign mag_q = s.acc_q[`TPD_ACC_W-1] ? 9'(-s.acc_q) : 9'(s.acc_q);
	assign energy = mag_i + mag_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule : tpd_correlator

// file: tpd_detector.sv
// tone pair detector: samples the zero-cross line bit, correlates 18 references
// over one window, picks a tone per group, checks sidebands, energy and timing
// assumes line_in is asynchronous to clock; digit consumer uses valid/ready
//
// Overview of operation
// - sample line at 8 kHz from timer
// - accumulate each correlation over 16 ms window
// - compute sidebands at minus and plus five percent
// - reject tone below minimum energy threshold
// - edges drive timer measuring activity and inactivity
// - pulses mean tone on, none mean pause
// - decide in 16 ms, under 23 ms on-time
// - strongest per group, reject if sideband higher
// - eighteen references, shared sidebands between neighbours
`timescale 1ns/10ps
`include "tpd_consts.svh"

module tpd_detector (
	input wire logic clock,
	input wire logic rst,
	input wire logic line_in,
	input wire logic [`TPD_THR_W-1:0] energy_thresh,
	output logic digit_valid,
	output logic [3:0] digit_code,
	input wire logic digit_ready,
	output logic digit_overflow,
	output tpd_pkg::tpd_reject_t reject,
	output logic line_active,
	output logic [`TPD_ON_W-1:0] tone_on_samples
);
	localparam logic [`TPD_DIV_W-1:0] DIV_LAST = `TPD_DIV_W'(`TPD_SAMPLE_DIV - 1);
	localparam logic [`TPD_WIN_W-1:0] WIN_LAST = `TPD_WIN_W'(`TPD_WINDOW_SAMPLES - 1);
	localparam logic [`TPD_IDLE_W-1:0] IDLE_LAST = `TPD_IDLE_W'(`TPD_IDLE_SAMPLES - 1);
	localparam logic [`TPD_ON_W-1:0] MIN_ON = `TPD_ON_W'(`TPD_MIN_ON_SAMPLES);
	localparam logic [`TPD_NUM_REF*`TPD_PHASE_W-1:0] INC_TABLE = `TPD_INC_TABLE;

	tpd_pkg::tpd_main_t s;
	tpd_pkg::tpd_main_t next_s;
	logic tick;
	logic line_edge;
	logic corr_clear;
	logic corr_sample;
	logic [`TPD_NUM_REF-1:0][`TPD_NRG_W-1:0] energy;

	// ------------------------------------------------------------
	// reference correlators
	// ------------------------------------------------------------

	genvar g;
	generate
		for (g = 0; g < `TPD_NUM_REF; g = g + 1) begin : gen_corr
			tpd_correlator u_corr (
				.clock(clock),
				.rst(rst),
				.clear(corr_clear),
				.sample_en(corr_sample),
				.line_bit(s.sync2),
				.phase_inc(INC_TABLE[g*`TPD_PHASE_W +: `TPD_PHASE_W]),
				.energy(energy[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// sampling, activity timing and decision
	// ------------------------------------------------------------

	always_comb begin
		int i;
		logic [1:0] lo;
		logic [1:0] hi;
		logic [`TPD_NRG_W-1:0] e_lo;
		logic [`TPD_NRG_W-1:0] e_hi;
		logic [4:0] n_lo;
		logic [4:0] n_hi;
		logic band_ok;
		logic nrg_ok;
		logic burst_end;
		i = 0;
		burst_end = 1'b0;
		lo = 2'h0;
		hi = 2'h0;
		e_lo = energy[`TPD_LOW_BASE];
		e_hi = energy[`TPD_HIGH_BASE];
		n_lo = 5'(`TPD_LOW_BASE);
		n_hi = 5'(`TPD_HIGH_BASE);
		band_ok = 1'b0;
		nrg_ok = 1'b0;
		next_s = s;
		corr_clear = 1'b0;
		corr_sample = 1'b0;
		next_s.overflow = 1'b0;
		next_s.rej = '0;

		// line bit passes two flops before anything looks at it
		next_s.sync1 = line_in;
		next_s.sync2 = s.sync1;
		next_s.prev = s.sync2;
		line_edge = s.sync2 ^ s.prev;

		// sample timer, exact divide of the system clock
		tick = (s.div == DIV_LAST);
		next_s.div = tick ? '0 : s.div + 1'b1;

		// any edge restarts the idle timer; a quiet spell ends the burst
		if (line_edge) begin
			next_s.idle = '0;
			next_s.active = 1'b1;
			if (!s.active) begin
				next_s.on_cnt = '0;
			end
		end else if (tick && s.active) begin
			if (s.idle == IDLE_LAST) begin
				next_s.active = 1'b0;
			end else begin
				next_s.idle = s.idle + 1'b1;
			end
		end
		if (tick && s.active && !line_edge && s.on_cnt != '1) begin
			next_s.on_cnt = s.on_cnt + 1'b1;
		end
		burst_end = s.active && !next_s.active;
		if (burst_end) begin
			next_s.last_on = s.on_cnt;
		end

		// strongest nominal tone in each group, low slots odd from 1, high from 10
		for (i = 1; i < 4; i = i + 1) begin
			if (energy[`TPD_LOW_BASE + 2*i] > e_lo) begin
				e_lo = energy[`TPD_LOW_BASE + 2*i];
				lo = 2'(i);
				n_lo = 5'(`TPD_LOW_BASE + 2*i);
			end
			if (energy[`TPD_HIGH_BASE + 2*i] > e_hi) begin
				e_hi = energy[`TPD_HIGH_BASE + 2*i];
				hi = 2'(i);
				n_hi = 5'(`TPD_HIGH_BASE + 2*i);
			end
		end
		// the neighbouring slots are the -5% and +5% sidebands
		band_ok = (energy[n_lo - 5'd1] <= e_lo) && (energy[n_lo + 5'd1] <= e_lo)
			&& (energy[n_hi - 5'd1] <= e_hi) && (energy[n_hi + 5'd1] <= e_hi);
		nrg_ok = (e_lo >= energy_thresh) && (e_hi >= energy_thresh);

		// consumer takes the held digit
		if (s.out_valid && digit_ready) begin
			next_s.out_valid = 1'b0;
		end

		case (s.state)
			tpd_pkg::TPD_IDLE: begin
				// a fresh burst starts a window on the edge that opened it
				if (line_edge && !s.active) begin
					corr_clear = 1'b1;
					next_s.win = '0;
					next_s.state = tpd_pkg::TPD_WINDOW;
				end
			end
			tpd_pkg::TPD_WINDOW: begin
				if (burst_end) begin
					next_s.rej.timing = 1'b1;
					next_s.state = tpd_pkg::TPD_IDLE;
				end else if (tick) begin
					corr_sample = 1'b1;
					if (s.win == WIN_LAST) begin
						next_s.state = tpd_pkg::TPD_EVAL;
					end else begin
						next_s.win = s.win + 1'b1;
					end
				end
			end
			tpd_pkg::TPD_EVAL: begin
				// decision taken right after the last window sample
				next_s.cand.row = lo;
				next_s.cand.col = hi;
				next_s.cand_ok = band_ok && nrg_ok;
				next_s.rej.freq = !band_ok;
				next_s.rej.energy = band_ok && !nrg_ok;
				next_s.state = burst_end ? tpd_pkg::TPD_IDLE : tpd_pkg::TPD_HOLD;
				// a burst cut in this cycle reports timing only, not a spectral verdict
				if (burst_end) begin
					next_s.rej = '0;
					next_s.rej.timing = 1'b1;
				end
			end
			tpd_pkg::TPD_HOLD: begin
				// digit is released only when the tone has ended long enough after starting
				if (burst_end) begin
					next_s.state = tpd_pkg::TPD_IDLE;
					if (s.on_cnt < MIN_ON) begin
						next_s.rej.timing = s.cand_ok;
					end else if (s.cand_ok) begin
						if (s.out_valid && !digit_ready) begin
							next_s.overflow = 1'b1;
						end else begin
							next_s.out = s.cand;
							next_s.out_valid = 1'b1;
						end
					end
				end
			end
			default: begin
				next_s.state = tpd_pkg::TPD_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// state register and outputs
	// ------------------------------------------------------------

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign digit_valid = s.out_valid;
	assign digit_code = {s.out.row, s.out.col};
	assign digit_overflow = s.overflow;
	assign reject = s.rej;
	assign line_active = s.active;
	assign tone_on_samples = s.last_on;

endmodule : tpd_detector

// file: tpd_detector_assertions.sv
// tone pair detector: port checker, bound to the top module
// assumes tpd_pkg is compiled first; one clock, async active-high reset
`timescale 1ns/10ps
`include "tpd_consts.svh"
module tpd_detector_assertions (
	input wire logic clock,
	input wire logic rst,
	input wire logic line_in,
	input wire logic digit_valid,
	input wire logic [3:0] digit_code,
	input wire logic digit_ready,
	input wire logic digit_overflow,
	input wire tpd_pkg::tpd_reject_t reject,
	input wire logic line_active,
	input wire logic [`TPD_ON_W-1:0] tone_on_samples
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ----
	// digit output
	// ----
	property p_hold; digit_valid && !digit_ready |=> digit_valid && $stable(digit_code); endproperty
	a_hold: assert property (p_hold) else $error("held digit lost");
	// a push at burst end wins over a pop in the same cycle
	property p_pop; digit_valid && digit_ready |=> !digit_valid || $fell(line_active); endproperty
	a_pop: assert property (p_pop) else $error("digit not popped");
	property p_push;
		$rose(digit_valid) |-> $fell(line_active) && tone_on_samples >= `TPD_MIN_ON_SAMPLES;
	endproperty
	a_push: assert property (p_push) else $error("digit at wrong moment");
	property p_ovf; digit_overflow |-> $past(digit_valid) && digit_valid && $fell(line_active); endproperty
	a_ovf: assert property (p_ovf) else $error("overflow misplaced");
	// ----
	// decisions and timing
	// ----
	property p_late;
		reject.timing |-> $fell(line_active) && tone_on_samples < `TPD_MIN_ON_SAMPLES;
	endproperty
	a_late: assert property (p_late) else $error("timing reject misplaced");
	property p_dec; reject.freq || reject.energy |-> line_active; endproperty
	a_dec: assert property (p_dec) else $error("decision outside burst");
	property p_one; reject.freq || reject.energy |=> !reject.freq && !reject.energy; endproperty
	a_one: assert property (p_one) else $error("reject longer than a pulse");
	property p_act; $changed(line_in) |-> ##[1:5] line_active; endproperty
	a_act: assert property (p_act) else $error("edge not seen as activity");
	property p_len; !$fell(line_active) |-> $stable(tone_on_samples); endproperty
	a_len: assert property (p_len) else $error("on-time moved mid burst");
	c_pop: cover property (digit_valid && digit_ready);
	c_freq: cover property (reject.freq);
	c_ovf: cover property (digit_overflow);
	c_time: cover property (reject.timing);
endmodule : tpd_detector_assertions

bind tpd_detector tpd_detector_assertions tpd_detector_assertions_inst (
	.clock(clock), .rst(rst), .line_in(line_in), .digit_valid(digit_valid),
	.digit_code(digit_code), .digit_ready(digit_ready), .digit_overflow(digit_overflow),
	.reject(reject), .line_active(line_active), .tone_on_samples(tone_on_samples)
);

// file: tpd_detector_tb.sv
// tone pair detector: self-checking bench, one task per scenario
// assumes the line model and checker are compiled before it
`timescale 1ns/10ps
`include "tpd_consts.svh"
module tpd_detector_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic line_in;
	logic [`TPD_THR_W-1:0] energy_thresh = 9'h020;
	logic digit_valid;
	logic [3:0] digit_code;
	logic digit_ready = 1'b0;
	logic digit_overflow;
	tpd_pkg::tpd_reject_t reject;
	logic line_active;
	logic [`TPD_ON_W-1:0] tone_on_samples;
	logic tone_on = 1'b0;
	logic [11:0] lo_hz = 12'h000;
	logic [11:0] hi_hz = 12'h000;
	logic [2:0] acc;
	logic ovf, act, dv;
	logic [3:0] dc;
	logic [`TPD_ON_W-1:0] ts;
	int errors = 0;
	int cmp_count = 0;

	tpd_detector tpd_detector_inst (.clock(clock), .rst(rst), .line_in(line_in),
		.energy_thresh(energy_thresh), .digit_valid(digit_valid), .digit_code(digit_code),
		.digit_ready(digit_ready), .digit_overflow(digit_overflow), .reject(reject),
		.line_active(line_active), .tone_on_samples(tone_on_samples));
	tpd_line_model tpd_line_model_inst (.tone_on(tone_on), .lo_hz(lo_hz), .hi_hz(hi_hz),
		.line_in(line_in));

	initial begin
		forever #20 clock = ~clock;
	end

	task final_report;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected at %0t got %0h exp %0h", $time, got, exp);
			errors++;
		end
	endtask : chk

	// sample just after an edge so registered outputs have settled
	task step;
		#1;
		acc = acc | reject;
		ovf = ovf | digit_overflow;
		act = line_active;
		dv = digit_valid;
		dc = digit_code;
		ts = tone_on_samples;
		@(posedge clock);
	endtask : step

	task automatic burst(input logic [11:0] lo, input logic [11:0] hi, input int ms);
		int n;
		lo_hz <= lo;
		hi_hz <= hi;
		tone_on <= 1'b1;
		acc = 3'h0;
		ovf = 1'b0;
		for (n = 0; n < ms * 25000; n++) begin
			step();
		end
		chk(act, 1'b1);
		tone_on <= 1'b0;
		act = 1'b1;
		for (n = 0; n < 60000 && act !== 1'b0; n++) begin
			step();
		end
		if (n == 60000) begin
			errors++;
			final_report();
		end
	endtask : burst

	// 770 + 1209 Hz for 25 ms
	task s_digit;
		burst(12'h302, 12'h4B9, 25);
		chk(acc, 3'h0);
		chk(dv, 1'b1);
		chk(dc, 4'h4);
		chk(ts >= 9'h0D0 && ts <= 9'h0E0, 1'b1);
	endtask : s_digit

	// 941 + 1633 Hz while the first digit is still unread
	task s_ovf;
		burst(12'h3AD, 12'h661, 25);
		chk(ovf, 1'b1);
		chk(dc, 4'h4);
		digit_ready <= 1'b1;
		step();
		digit_ready <= 1'b0;
		step();
		chk(dv, 1'b0);
	endtask : s_ovf

	// 10 ms burst ends before the window does
	task s_short;
		burst(12'h354, 12'h538, 10);
		chk(acc, 3'h1);
		chk(dv, 1'b0);
	endtask : s_short

	// 742 Hz sits 3.6 percent under 770, its lower sideband wins
	task s_band;
		burst(12'h2E6, 12'h4B9, 25);
		chk(acc[2], 1'b1);
		chk(dv, 1'b0);
	endtask : s_band

	task s_energy;
		energy_thresh <= 9'h1FF;
		burst(12'h2B9, 12'h5C5, 25);
		chk(acc[1], 1'b1);
		chk(dv, 1'b0);
		energy_thresh <= 9'h020;
	endtask : s_energy

	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		s_digit();
		s_ovf();
		s_short();
		s_band();
		s_energy();
		final_report();
	end
endmodule : tpd_detector_tb

// file: tpd_line_model.sv
// tone pair detector: zero-cross detector fed by a two-tone line
// assumes nothing of the clock; output updates every microsecond while tone_on is high
`timescale 1ns/10ps
module tpd_line_model (
	input wire logic tone_on,
	input wire logic [11:0] lo_hz,
	input wire logic [11:0] hi_hz,
	output logic line_in
);
	real t;
	initial begin
		line_in = 1'b0;
		t = 0.0;
		forever begin
			#1000;
			// silence leaves the comparator output standing still
			if (tone_on) begin
				t = t + 1.0e-6;
				line_in = ($sin(6.283185 * lo_hz * t) + $sin(6.283185 * hi_hz * t)) >= 0.0;
			end else begin
				t = 0.0;
			end
		end
	end
endmodule : tpd_line_model

// file: tpd_pkg.sv
// tone pair detector: shared types
// assumes tpd_consts.svh is on the include path
`include "tpd_consts.svh"

package tpd_pkg;

	typedef enum logic [1:0] {
		TPD_IDLE = 2'b00,
		TPD_WINDOW = 2'b01,
		TPD_EVAL = 2'b10,
		TPD_HOLD = 2'b11
	} tpd_state_t;

	typedef struct packed {
		logic [1:0] row;
		logic [1:0] col;
	} tpd_digit_t;

	typedef struct packed {
		logic freq;
		logic energy;
		logic timing;
	} tpd_reject_t;

	typedef struct packed {
		logic [`TPD_PHASE_W-1:0] phase;
		logic signed [`TPD_ACC_W-1:0] acc_i;
		logic signed [`TPD_ACC_W-1:0] acc_q;
	} tpd_corr_t;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic [`TPD_DIV_W-1:0] div;
		logic [`TPD_WIN_W-1:0] win;
		logic [`TPD_IDLE_W-1:0] idle;
		logic active;
		logic [`TPD_ON_W-1:0] on_cnt;
		logic [`TPD_ON_W-1:0] last_on;
		tpd_state_t state;
		logic cand_ok;
		tpd_digit_t cand;
		logic out_valid;
		tpd_digit_t out;
		logic overflow;
		tpd_reject_t rej;
	} tpd_main_t;

endpackage : tpd_pkg
